// ---- hw/uart_map.vh ----
// register offsets, field positions, reset values and bit timing of the serial port
// assumes a 32-bit avalon-mm slave, byte addresses, one register per aligned word
`ifndef UART_MAP_VH
`define UART_MAP_VH

`define REG_CTRL 5'h00
`define REG_BUF 5'h04
`define REG_STAT 5'h08
`define REG_MASK 5'h0c
`define REG_DIV 5'h10

`define CTL_MODE 0
`define CTL_FILT 2
`define CTL_REN 3
`define CTL_TB8 4
`define CTL_RB8 5
`define CTL_DBL 6
`define CTL_SIX 7
`define CTL_RXDONE 8
`define CTL_TXDONE 9

`define ST_RX 0
`define ST_TX 1
`define ST_OVR 2
`define ST_FRM 3

`define MODE_RST 2'h0
`define MASK_RST 4'h0
`define DIV_RST 16'h000f

`define OVERSAMPLE 16
`define HALF_TICK 4'h7
`define LAST_TICK 4'hf
`define OSC_PER_BIT_12T 64
`define OSC_PER_BIT_6T 32

`endif

// ---- hw/uart_rx_frame.v ----
// receive framer: start detect, mid-bit sampling, eight or nine data bits and stop
// assumes rxd synchronous to clk and tick pulsing sixteen times per bit period
`timescale 1ns/10ps
`include "uart_map.vh"
module uart_rx_frame (
   input wire clk,
   input wire resetn,
   input wire tick,
   input wire enable,
   input wire nine,
   input wire rxd,
   output reg done,
   output reg [7:0] data,
   output reg bit9,
   output reg stop
);
   localparam IDLE = 2'd0;
   localparam START = 2'd1;
   localparam DATA = 2'd2;
   localparam STOP = 2'd3;
   reg [1:0] state_q;
   reg [3:0] tick_q;
   reg [3:0] bit_q;
   reg rxd_q;

   always @(posedge clk) begin
      if (!resetn) begin
         state_q <= IDLE;
         tick_q <= 4'h0;
         bit_q <= 4'h0;
         rxd_q <= 1'b1;
         done <= 1'b0;
         data <= 8'h00;
         bit9 <= 1'b0;
         stop <= 1'b1;
      end else begin
         done <= 1'b0;
         rxd_q <= rxd;
         case (state_q)
            IDLE: begin
               tick_q <= 4'h0;
               bit_q <= 4'h0;
               if (enable && rxd_q && !rxd) begin
                  state_q <= START;
               end
            end
            START: begin
               if (tick) begin
                  tick_q <= tick_q + 4'h1;
                  if (tick_q == `HALF_TICK) begin
                     tick_q <= 4'h0;
                     // a glitch shorter than half a bit is not a frame
                     state_q <= rxd ? IDLE : DATA;
                  end
               end
            end
            DATA: begin
               if (tick) begin
                  tick_q <= tick_q + 4'h1;
                  if (tick_q == `LAST_TICK) begin
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == 4'h8) begin
                        bit9 <= rxd;
                     end else begin
                        data <= {rxd, data[7:1]};
                     end
                     if (bit_q == (nine ? 4'h8 : 4'h7)) begin
                        state_q <= STOP;
                     end
                  end
               end
            end
            default: begin
               if (tick) begin
                  tick_q <= tick_q + 4'h1;
                  if (tick_q == `LAST_TICK) begin
                     stop <= rxd;
                     if (!nine) begin
                        bit9 <= rxd;
                     end
                     done <= 1'b1;
                     // back to edge watch at mid stop bit
                     state_q <= IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule // uart_rx_frame

// ---- hw/uart_tx_frame.v ----
// transmit framer: shifts start, eight data bits, optional ninth bit and stop
// assumes tick pulses sixteen times per bit; start is ignored while busy
`timescale 1ns/10ps
`include "uart_map.vh"
module uart_tx_frame (
   input wire clk,
   input wire resetn,
   input wire tick,
   input wire start,
   input wire nine,
   input wire ninth,
   input wire [7:0] data,
   output wire txd,
   output wire busy,
   output reg done
);
   reg [10:0] shift_q;
   reg [3:0] tick_q;
   reg [3:0] left_q;

   assign busy = left_q != 4'h0;
   assign txd = shift_q[0];

   always @(posedge clk) begin
      if (!resetn) begin
         shift_q <= 11'h7ff;
         tick_q <= 4'h0;
         left_q <= 4'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            // eight-bit frames put the stop in the ninth slot; the top stop is sent only in nine-bit frames
            shift_q <= {1'b1, nine ? ninth : 1'b1, data, 1'b0};
            left_q <= nine ? 4'hb : 4'ha;
            tick_q <= 4'h0;
         end else if (busy && tick) begin
            tick_q <= tick_q + 4'h1;
            if (tick_q == `LAST_TICK) begin
               shift_q <= {1'b1, shift_q[10:1]};
               left_q <= left_q - 4'h1;
               if (left_q == 4'h1) begin
                  done <= 1'b1;
               end
            end
         end
      end
   end
endmodule // uart_tx_frame

// ---- hw/uart_nine_bit_multidrop.v ----
// serial port top: avalon-mm registers, bit-rate divider, frame acceptance, interrupt
// assumes one clock (the oscillator), synchronous active-low reset, rxd already synchronous
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "uart_map.vh"
module uart_nine_bit_multidrop (
   input wire clk,
   input wire resetn,
   input wire [4:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   output reg [31:0] readdata,
   output wire waitrequest,
   output wire irq,
   input wire rxd,
   output wire txd
);
   reg [1:0] mode_q;
   reg filt_q;
   reg ren_q;
   reg tb8_q;
   reg rb8_q;
   reg dbl_q;
   reg six_q;
   reg rx_done_flag_q;
   reg tx_done_flag_q;
   reg [7:0] rbuf_q;
   reg [3:0] stat_q;
   reg [3:0] mask_q;
   reg [15:0] div_q;
   reg [15:0] cnt_q;
   reg ack_q;
   reg [31:0] rd_d;
   reg tick;

   wire tx_busy;
   wire tx_fin;
   wire rx_fin;
   wire [7:0] rx_data;
   wire rx_bit9;
   wire rx_stop;

   // merges one byte lane of a write into an old value
   function [7:0] lane;
      input [7:0] old;
      input [7:0] nval;
      input en;
      begin
         lane = en ? nval : old;
      end
   endfunction

   // cycles of clk per sixteenth of a bit
   function [15:0] tick_len;
      input [1:0] mode;
      input six;
      input dbl;
      input [15:0] div;
      reg [31:0] per_bit;
      begin
         per_bit = six ? `OSC_PER_BIT_6T : `OSC_PER_BIT_12T;
         if (dbl) begin
            per_bit = per_bit >> 1;
         end
         per_bit = per_bit / `OVERSAMPLE;
         if (mode[0]) begin
            tick_len = div + 16'h0001;
         end else begin
            tick_len = per_bit[15:0];
         end
      end
   endfunction

   wire req = read | write;
   wire taken = req & ack_q;
   wire wr = write & ack_q;
   wire rd = read & ack_q;
   assign waitrequest = req & ~ack_q;

   wire nine = mode_q[1];
   // mode 0 keeps the filter out; 1 checks stop, 2 and 3 check the ninth bit
   wire filt_on = filt_q & (mode_q != 2'h0);
   wire accept = rx_fin & ~rx_done_flag_q & (~filt_on | rx_bit9);
   wire overrun = rx_fin & rx_done_flag_q;
   wire framing = rx_fin & ~rx_stop;

   wire ctl_wr = wr & (address == `REG_CTRL);
   wire buf_wr = wr & (address == `REG_BUF) & byteenable[0];
   wire stat_rd = rd & (address == `REG_STAT);
   wire [15:0] next_len = tick_len(mode_q, six_q, dbl_q, div_q);

   // bus handshake: one wait state, the answer comes on the second cycle
   always @(posedge clk) begin
      if (!resetn) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req & ~ack_q;
      end
   end

   // free-running sixteen-per-bit enable; a new rate applies at the next reload
   always @(posedge clk) begin
      if (!resetn) begin
         cnt_q <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (cnt_q == 16'h0000) begin
            cnt_q <= next_len - 16'h0001;
            tick <= 1'b1;
         end else begin
            cnt_q <= cnt_q - 16'h0001;
         end
      end
   end

   // control fields written by software
   always @(posedge clk) begin
      if (!resetn) begin
         mode_q <= `MODE_RST;
         filt_q <= 1'b0;
         ren_q <= 1'b0;
         tb8_q <= 1'b0;
         dbl_q <= 1'b0;
         six_q <= 1'b0;
         mask_q <= `MASK_RST;
         div_q <= `DIV_RST;
      end else if (wr) begin
         if (address == `REG_CTRL && byteenable[0]) begin
            mode_q <= writedata[`CTL_MODE+1:`CTL_MODE];
            filt_q <= writedata[`CTL_FILT];
            ren_q <= writedata[`CTL_REN];
            tb8_q <= writedata[`CTL_TB8];
            dbl_q <= writedata[`CTL_DBL];
            six_q <= writedata[`CTL_SIX];
         end else if (address == `REG_MASK && byteenable[0]) begin
            mask_q <= writedata[3:0];
         end else if (address == `REG_DIV) begin
            div_q[7:0] <= lane(div_q[7:0], writedata[7:0], byteenable[0]);
            div_q[15:8] <= lane(div_q[15:8], writedata[15:8], byteenable[1]);
         end
      end
   end

   // receive buffer and done flags; a hardware set wins over a software clear
   always @(posedge clk) begin
      if (!resetn) begin
         rbuf_q <= 8'h00;
         rb8_q <= 1'b0;
         rx_done_flag_q <= 1'b0;
         tx_done_flag_q <= 1'b0;
      end else begin
         if (ctl_wr && byteenable[1] && !writedata[`CTL_RXDONE]) begin
            rx_done_flag_q <= 1'b0;
         end
         if (ctl_wr && byteenable[1] && !writedata[`CTL_TXDONE]) begin
            tx_done_flag_q <= 1'b0;
         end
         if (accept) begin
            rbuf_q <= rx_data;
            rb8_q <= rx_bit9;
            rx_done_flag_q <= 1'b1;
         end
         // a rejected frame leaves buffer, ninth bit and flag untouched
         if (tx_fin) begin
            tx_done_flag_q <= 1'b1;
         end
      end
   end

   // sticky event status, cleared by reading it; only bits seen are cleared
   always @(posedge clk) begin
      if (!resetn) begin
         stat_q <= 4'h0;
      end else begin
         stat_q <= (stat_q & ~(stat_rd ? readdata[3:0] : 4'h0))
            | {framing, overrun, tx_fin, accept};
      end
   end

   assign irq = |(stat_q & mask_q);

   // read mux, captured in the waiting cycle so it stands at the answer edge
   always @* begin
      rd_d = 32'h00000000;
      if (address == `REG_CTRL) begin
         rd_d[`CTL_MODE+1:`CTL_MODE] = mode_q;
         rd_d[`CTL_FILT] = filt_q;
         rd_d[`CTL_REN] = ren_q;
         rd_d[`CTL_TB8] = tb8_q;
         rd_d[`CTL_RB8] = rb8_q;
         rd_d[`CTL_DBL] = dbl_q;
         rd_d[`CTL_SIX] = six_q;
         rd_d[`CTL_RXDONE] = rx_done_flag_q;
         rd_d[`CTL_TXDONE] = tx_done_flag_q;
      end else if (address == `REG_BUF) begin
         rd_d[7:0] = rbuf_q;
      end else if (address == `REG_STAT) begin
         rd_d[3:0] = stat_q;
      end else if (address == `REG_MASK) begin
         rd_d[3:0] = mask_q;
      end else if (address == `REG_DIV) begin
         rd_d[15:0] = div_q;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         readdata <= 32'h00000000;
      end else if (read && !ack_q) begin
         readdata <= rd_d;
      end
   end

   uart_tx_frame u_tx (
      .clk(clk),
      .resetn(resetn),
      .tick(tick),
      .start(buf_wr),
      .nine(nine),
      .ninth(tb8_q),
      .data(writedata[7:0]),
      .txd(txd),
      .busy(tx_busy),
      .done(tx_fin)
   );

   uart_rx_frame u_rx (
      .clk(clk),
      .resetn(resetn),
      .tick(tick),
      .enable(ren_q),
      .nine(nine),
      .rxd(rxd),
      .done(rx_fin),
      .data(rx_data),
      .bit9(rx_bit9),
      .stop(rx_stop)
   );
endmodule // uart_nine_bit_multidrop

// ---- verification/uart_port_monitor.sv ----
// checker for the serial port top: bus handshake, readback hold, irq masking, txd bit shapes
// assumes only the top ports are visible; bound to the top at the foot of this file
`timescale 1ns/10ps
`include "uart_map.vh"
module uart_port_monitor (
   input wire clk,
   input wire resetn,
   input wire [4:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   input wire [3:0] byteenable,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire irq,
   input wire rxd,
   input wire txd
);
   reg [3:0] mask_q;
   // shadow of the mask register, so irq can be tied to it
   always @(posedge clk) begin
      if (!resetn)
         mask_q <= 4'h0;
      else if (write && !waitrequest && address == `REG_MASK && byteenable[0])
         mask_q <= writedata[3:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // every bit lasts at least sixteen clocks, so eight is a safe floor
   sequence low_run;
      !txd [*8];
   endsequence
   sequence high_run;
      txd [*8];
   endsequence
   AST_WAIT_FIRST: assert property ($rose(read || write) |-> waitrequest)
      else $error("new request without a wait state");
   AST_WAIT_ONE: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("wait state longer than one cycle");
   AST_IDLE_NOWAIT: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest high while idle");
   AST_RD_HOLD: assert property (!(read && waitrequest) |=> $stable(readdata))
      else $error("readdata moved without a read");
   AST_RESET_OUT: assert property ($rose(resetn) |-> txd && !irq)
      else $error("txd or irq wrong after reset");
   AST_IRQ_MASKED: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !irq)
      else $error("irq high with all sources masked");
   AST_TX_START: assert property (write && !waitrequest && address == `REG_BUF && byteenable[0] |=> !txd)
      else $error("txd did not start after buffer write");
   AST_BIT_LOW: assert property ($fell(txd) |-> low_run)
      else $error("low bit on txd too short");
   AST_BIT_HIGH: assert property ($rose(txd) |-> high_run)
      else $error("high bit on txd too short");
endmodule // uart_port_monitor

bind uart_nine_bit_multidrop uart_port_monitor u_chk (.clk(clk), .resetn(resetn), .address(address),
   .read(read), .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .irq(irq), .rxd(rxd), .txd(txd));

// ---- verification/serial_node.sv ----
// far serial node: drives frames onto the port's rxd and captures frames from its txd
// assumes tasks are called at a clock edge; bit time is given in clk cycles
`timescale 1ns/10ps
module serial_node (
   input wire clk,
   input wire txd,
   output reg rxd
);
   initial rxd = 1'b1;
   task send(input [7:0] d, input n, input integer bit_t);
      integer i;
      reg [10:0] f;
      begin
         f = {1'b1, n, d, 1'b0};
         for (i = 0; i < 11; i = i + 1) begin
            rxd <= f[i];
            repeat (bit_t) @(posedge clk);
         end
      end
   endtask
   // short low pulse, then idle long enough for a mid-bit recheck to give up
   task glitch;
      begin
         rxd <= 1'b0;
         repeat (3) @(posedge clk);
         rxd <= 1'b1;
         repeat (16) @(posedge clk);
      end
   endtask
   task grab(input integer bit_t, output [7:0] d, output n, output s);
      integer i;
      reg [10:0] f;
      begin
         while (txd !== 1'b0) @(posedge clk);
         repeat (bit_t / 2) @(posedge clk);
         for (i = 0; i < 11; i = i + 1) begin
            f[i] = txd;
            repeat (bit_t) @(posedge clk);
         end
         {s, n, d} = f[10:1];
      end
   endtask
endmodule // serial_node

// ---- verification/tb.sv ----
// self-checking bench for the nine-bit multidrop serial port
// assumes the design top, the far node model and the checker bound to the top
`timescale 1ns/10ps
`include "uart_map.vh"
module tb;
   reg clk, resetn, read, write;
   reg [4:0] address;
   reg [31:0] writedata, v;
   reg [3:0] byteenable;
   wire [31:0] readdata;
   wire waitrequest, irq, rxd, txd;
   integer fails = 0, comparisons = 0, cyc = 0;
   reg [7:0] d;
   reg n, s;
   uart_nine_bit_multidrop u_dut (.clk(clk), .resetn(resetn), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .rxd(rxd), .txd(txd));
   serial_node u_node (.clk(clk), .txd(txd), .rxd(rxd));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task end_of_test;
      begin
         $display("comparisons %0d fails %0d", comparisons, fails);
         if (fails == 0 && comparisons > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails = fails + 1;
         end_of_test;
      end
   end
   task chk(input [8*8-1:0] what, input [31:0] e, input [31:0] g);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            fails = fails + 1;
            $display("[FAIL] %0s expected %h seen %h", what, e, g);
         end
      end
   endtask
   // one avalon transfer; the request is held until waitrequest is seen low
   task bus(input wr, input [4:0] a, input [31:0] wd, input [3:0] be);
      begin
         address <= a;
         writedata <= wd;
         byteenable <= be;
         read <= !wr;
         write <= wr;
         // waitrequest is judged where it is settled, before the edge that takes the transfer
         @(negedge clk);
         while (waitrequest !== 1'b0) begin
            @(posedge clk);
            @(negedge clk);
         end
         @(posedge clk);
         v = readdata;
         read <= 1'b0;
         write <= 1'b0;
         @(posedge clk);
      end
   endtask
   task rc(input [4:0] a, input [31:0] e);
      begin
         bus(0, a, 0, 0);
         chk("readback", e, v);
      end
   endtask
   task t_regs;
      integer i;
      begin
         for (i = 0; i < 6; i = i + 1)
            rc(i * 4, (i == 4) ? 32'h000f : 32'h0);
         bus(1, `REG_DIV, 32'h0, 4'hf);
         rc(`REG_DIV, 32'h0);
         $display("regs test ended");
      end
   endtask
   task t_rate;
      integer i, len;
      begin
         bus(1, `REG_MASK, 32'h2, 4'hf);
         for (i = 0; i < 4; i = i + 1) begin
            bus(1, `REG_CTRL, {i[1:0], 6'h12}, 4'h3);
            bus(1, `REG_BUF, 32'h01, 4'hf);
            while (txd !== 1'b1) @(posedge clk);
            len = 0;
            while (txd === 1'b1) begin
               @(posedge clk);
               len = len + 1;
            end
            chk("bit_len", (i == 0) ? 64 : (i == 3) ? 16 : 32, len);
            while (irq !== 1'b1) @(posedge clk);
            rc(`REG_STAT, 32'h2);
         end
         $display("rate test ended");
      end
   endtask
   task t_tx;
      begin
         bus(1, `REG_CTRL, 32'h13, 4'h3);
         bus(1, `REG_BUF, 32'ha5, 4'hf);
         u_node.grab(16, d, n, s);
         chk("tx_data", 32'ha5, d);
         chk("tx_ninth", 32'h1, n);
         chk("tx_stop", 32'h1, s);
         chk("irq", 32'h1, irq);
         rc(`REG_CTRL, 32'h213);
         rc(`REG_STAT, 32'h2);
         chk("irq", 32'h0, irq);
         $display("tx test ended");
      end
   endtask
   task t_rx;
      begin
         bus(1, `REG_MASK, 32'h1, 4'hf);
         bus(1, `REG_CTRL, 32'h0b, 4'h3);
         u_node.glitch;
         u_node.send(8'h3c, 1'b0, 16);
         chk("irq", 32'h1, irq);
         u_node.send(8'h55, 1'b1, 16);
         rc(`REG_BUF, 32'h3c);
         rc(`REG_CTRL, 32'h10b);
         rc(`REG_STAT, 32'h5);
         $display("rx test ended");
      end
   endtask
   task t_filter;
      begin
         bus(1, `REG_CTRL, 32'h07, 4'h3);
         u_node.send(8'h42, 1'b1, 16);
         rc(`REG_BUF, 32'h3c);
         bus(1, `REG_CTRL, 32'h0f, 4'h3);
         u_node.send(8'h11, 1'b0, 16);
         chk("irq", 32'h0, irq);
         u_node.send(8'h42, 1'b1, 16);
         chk("irq", 32'h1, irq);
         rc(`REG_CTRL, 32'h12f);
         bus(1, `REG_CTRL, 32'h0b, 4'h3);
         u_node.send(8'h77, 1'b0, 16);
         rc(`REG_BUF, 32'h77);
         bus(1, `REG_CTRL, 32'h0c, 4'h3);
         u_node.send(8'h99, 1'b0, 64);
         rc(`REG_BUF, 32'h99);
         bus(1, `REG_CTRL, 32'h0d, 4'h3);
         u_node.send(8'h24, 1'b0, 16);
         rc(`REG_BUF, 32'h99);
         $display("filter test ended");
      end
   endtask
   initial begin
      resetn = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 5'h0;
      writedata = 32'h0;
      byteenable = 4'h0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      t_regs;
      t_rate;
      t_tx;
      t_rx;
      t_filter;
      end_of_test;
   end
endmodule // tb
